// File: common/ascc_div_if.sv
`timescale 1ns/1ps
interface ascc_div_if #(
  parameter int W = 3
);
  logic         edge_in;
  logic         clear;
  logic [W-1:0] last;
  logic         tick;
  logic         half;
  logic [W-1:0] count;

  modport ctrl (output edge_in, output clear, output last, input tick, input half, input count);
  modport div  (input edge_in, input clear, input last, output tick, output half, output count);
endinterface

// File: common/ascc_pkg.sv
// Function
// (RULE_01) Nyquist clock or RF clock divided by four
// (RULE_02) Source select register, resets to Nyquist
// (RULE_03) Integer divider from one to eight
// (RULE_04) RF predivider sits before the divider
// (RULE_05) One ratio field serves both sources
// (RULE_06) Ratio above one forces the stabilizer on
// (RULE_07) SYSREF resync on every pulse or once
// (RULE_08) Accepted SYSREF returns divider to start
// (RULE_09) Keep rising edge, regenerate falling edge
// (RULE_10) Stabilizer inactive below minimum clock rate
// (RULE_11) Host waits relock time after frequency change
// (RULE_12) Unlocked stabilizer is bypassed
// (RULE_13) Power-down by pin high or serial port
// (RULE_14) Pin low returns to normal operation
// (RULE_15) Power-down stops reference, buffer, bias, clock
// (RULE_16) Standby keeps reference powered
// (RULE_17) Serial setting adjusts reference voltage
// (RULE_18) Samples taken on divided clock rising edge
// (RULE_19) Source or ratio change forces a relock
package ascc_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_DIV_RATIO = 8'h08;
  localparam logic [7:0] ADDR_SRC_SEL   = 8'h09;
  localparam logic [7:0] ADDR_RESYNC    = 8'h3A;

  // Reset values
  localparam logic [7:0] RST_DIV_RATIO = 8'h00;
  localparam logic [7:0] RST_SRC_SEL   = 8'h00;
  localparam logic [7:0] RST_RESYNC    = 8'h00;

  // Field layout
  localparam int DIV_W            = 3;
  localparam int DIV_LSB          = 0;
  localparam int SRC_RF_BIT       = 0;
  localparam int RESYNC_EVERY_BIT = 1;
  localparam int RESYNC_ONCE_BIT  = 2;

  // Divider figures
  localparam int RF_PREDIV   = 4;
  localparam int PREDIV_W    = 2;
  localparam int DIV_MAX     = 8;

  // Timing, in printed units, then in cycles of the 250 MHz clock
  localparam real CLK_MHZ        = 250.0;
  localparam real DCS_RELOCK_US  = 1.5;
  localparam real DCS_MIN_MHZ    = 40.0;
  localparam int  DCS_RELOCK_CYC = int'($ceil(DCS_RELOCK_US * CLK_MHZ));
  localparam int  DCS_MAX_PERIOD = int'($floor(CLK_MHZ / DCS_MIN_MHZ));

  // Power modes
  typedef enum logic [1:0] {
    ASCC_PWR_RUN     = 2'b00,
    ASCC_PWR_STANDBY = 2'b01,
    ASCC_PWR_DOWN    = 2'b10
  } ascc_pwr_t;

endpackage

// File: dv/adc_sample_clock_control_test.sv
`timescale 1ns/1ps
module adc_sample_clock_control_test;
  logic       clock = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, rd_seen = 1'b0;
  logic       run = 1'b0, rf_sel = 1'b0, sysref = 1'b0, pd_pin = 1'b0;
  logic       spd = 1'b0, sstb = 1'b0, dcs_en = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, d, gap = 8'h00, hi = 8'h00;
  logic [7:0] ecnt = 8'h00, hcnt = 8'h00, rdata;
  logic [4:0] radj = 5'h00, adj;
  logic       nyq_r, nyq_f, rf_r, tick, sclk, duty_cycle_stabilizer, src_edge;
  logic [3:0] en;
  int         fails = 0, tests_run = 0, ntick = 0, n0;
  logic [7:0] exp_q[$];

  initial begin
    forever #2 clock = ~clock;
  end

  ascc_src_model SRC (.clock(clock), .run(run), .rf_sel(rf_sel), .nyq_rise(nyq_r),
                      .nyq_fall(nyq_f), .rf_rise(rf_r));

  ascc_top #(.RELOCK_CYC(8)) DUT (
    .clock(clock), .reset(reset), .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr),
    .reg_wr_data(wdata), .reg_rd_data(rdata), .nyq_clk_rise(nyq_r), .nyq_clk_fall(nyq_f),
    .rf_clock_input_rise(rf_r), .sysref_pin(sysref), .power_down_pin(pd_pin),
    .spi_power_down(spd), .spi_standby(sstb), .spi_duty_cycle_stabilizer_en(dcs_en),
    .spi_ref_adjust(radj), .sample_tick(tick), .sample_clk(sclk),
    .duty_cycle_stabilizer_active(duty_cycle_stabilizer), .ref_enable(en[3]), .ref_buffer_enable(en[2]),
    .bias_enable(en[1]), .clock_enable(en[0]), .ref_adjust(adj));

  assign src_edge = rf_sel ? rf_r : nyq_r;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Step to just after a rising edge, where all stimulus changes
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // One idle cycle after each strobe so it is never raised twice in a step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    addr = a;
    wdata = v;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    exp_q.push_back(e);
    cyc(1);
    rd = 1'b0;
    cyc(1);
  endtask

  // Source edges counted from restart up to the first sample tick
  task automatic edges_to_tick(input logic [7:0] e);
    logic [7:0] n;
    n = 8'h00;
    for (int k = 0; k < 64; k++) begin
      @(negedge clock);
      if (tick === 1'b1) break;
      n = n + 8'(src_edge);
    end
    check(n, e);
    cyc(1);
  endtask

  task automatic sysref_pulse;
    run = 1'b0;
    cyc(4);
    sysref = 1'b1;
    cyc(6);
    sysref = 1'b0;
    cyc(2);
    run = 1'b1;
  endtask

  // Read data is registered, so it is judged one cycle after the strobe
  always @(posedge clock) rd_seen <= rd;
  always @(negedge clock) begin
    if (rd_seen) check(rdata, exp_q.pop_front());
  end

  // Edges per sample period and high cycles per period, latched at each tick
  always @(posedge clock) begin
    if (tick === 1'b1) begin
      gap   <= ecnt;
      hi    <= hcnt;
      ecnt  <= 8'(src_edge);
      hcnt  <= 8'(sclk);
      ntick <= ntick + 1;
    end else begin
      ecnt <= ecnt + 8'(src_edge);
      hcnt <= hcnt + 8'(sclk);
    end
  end

  // Watchdog sized well above the whole sequence
  initial begin
    #60000;
    fails++;
    end_sim();
  end

  initial begin
    void'($urandom(32'h233ed52a));
    cyc(6);
    reset = 1'b0;
    rd_reg(ascc_pkg::ADDR_DIV_RATIO, ascc_pkg::RST_DIV_RATIO);
    rd_reg(ascc_pkg::ADDR_SRC_SEL, ascc_pkg::RST_SRC_SEL);
    rd_reg(ascc_pkg::ADDR_RESYNC, ascc_pkg::RST_RESYNC);
    d = 8'($urandom);
    wr_reg(8'h10, d);
    rd_reg(8'h10, 8'h00);
    wr_reg(ascc_pkg::ADDR_DIV_RATIO, d);
    rd_reg(ascc_pkg::ADDR_DIV_RATIO, d & 8'h07);
    wr_reg(ascc_pkg::ADDR_SRC_SEL, d);
    rd_reg(ascc_pkg::ADDR_SRC_SEL, d & 8'h01);
    wr_reg(ascc_pkg::ADDR_RESYNC, d);
    rd_reg(ascc_pkg::ADDR_RESYNC, d & 8'h06);
    wr_reg(ascc_pkg::ADDR_SRC_SEL, 8'h00);
    // Every ratio on the Nyquist path, extremes on the RF path
    run = 1'b1;
    dcs_en = 1'b1;
    for (int r = 1; r <= 8; r++) begin
      wr_reg(ascc_pkg::ADDR_DIV_RATIO, 8'(r - 1));
      cyc(8 * r + 8);
      check(gap, 8'(r));
    end
    wr_reg(ascc_pkg::ADDR_SRC_SEL, 8'h01);
    rf_sel = 1'b1;
    for (int r = 1; r <= 8; r += 7) begin
      wr_reg(ascc_pkg::ADDR_DIV_RATIO, 8'(r - 1));
      cyc(16 * r + 8);
      check(gap, 8'(4 * r));
    end
    wr_reg(ascc_pkg::ADDR_SRC_SEL, 8'h00);
    rf_sel = 1'b0;
    // Stabilizer: own enable, forced enable, relock, slow clock
    wr_reg(ascc_pkg::ADDR_DIV_RATIO, 8'h00);
    cyc(60);
    check({7'h0, duty_cycle_stabilizer}, 8'h01);
    dcs_en = 1'b0;
    cyc(60);
    check({7'h0, duty_cycle_stabilizer}, 8'h00);
    check(hi, 8'h01);
    wr_reg(ascc_pkg::ADDR_DIV_RATIO, 8'h01);
    check({7'h0, duty_cycle_stabilizer}, 8'h00);
    cyc(60);
    check({7'h0, duty_cycle_stabilizer}, 8'h01);
    check(hi, 8'h02);
    wr_reg(ascc_pkg::ADDR_DIV_RATIO, 8'h03);
    cyc(60);
    check({7'h0, duty_cycle_stabilizer}, 8'h00);
    // Resync on every pulse, then once only
    wr_reg(ascc_pkg::ADDR_RESYNC, 8'h02);
    sysref_pulse();
    edges_to_tick(8'h01);
    wr_reg(ascc_pkg::ADDR_RESYNC, 8'h04);
    sysref_pulse();
    edges_to_tick(8'h01);
    run = 1'b0;
    sysref_pulse();
    edges_to_tick(8'h03);
    // Power-down by pin and by serial-port input, then standby and trim
    pd_pin = 1'b1;
    cyc(2);
    check({4'h0, en}, 8'h0F);
    cyc(1);
    check({4'h0, en}, 8'h00);
    // A tick launched on the power-down edge is still counted one cycle later
    cyc(1);
    n0 = ntick;
    cyc(20);
    check(8'(ntick - n0), 8'h00);
    check({7'h0, sclk}, 8'h00);
    pd_pin = 1'b0;
    cyc(3);
    check({4'h0, en}, 8'h0F);
    spd = 1'b1;
    sstb = 1'b1;
    cyc(1);
    check({4'h0, en}, 8'h00);
    spd = 1'b0;
    cyc(1);
    check({4'h0, en}, 8'h0C);
    sstb = 1'b0;
    radj = 5'($urandom);
    cyc(1);
    check({3'h0, adj}, {3'h0, radj});
    end_sim();
  end
endmodule

// File: dv/ascc_src_model.sv
`timescale 1ns/1ps
// Far-side clock source, edges change just after the system clock edge
module ascc_src_model (
  input  wire logic clock,
  input  wire logic run,
  input  wire logic rf_sel,
  output logic      nyq_rise,
  output logic      nyq_fall,
  output logic      rf_rise
);
  logic go;
  logic sel;
  logic ph = 1'b0;
  initial begin
    nyq_rise = 1'b0;
    nyq_fall = 1'b0;
    rf_rise  = 1'b0;
  end
  // Nyquist rise and fall alternate; no pulses at all while stopped
  always @(posedge clock) begin
    // Select taken at the edge too, so it never races the bench's own update
    go  = run;
    sel = rf_sel;
    #1;
    ph       = go & ~ph;
    nyq_rise = go & ~sel & ph;
    nyq_fall = go & ~sel & ~ph;
    rf_rise  = go & sel;
  end
endmodule

// File: rtl/ascc_divider.sv
`timescale 1ns/1ps
module ascc_divider #(
  parameter int W = 3
) (
  input  wire logic clock,
  input  wire logic reset,
  ascc_div_if.div   port_if
);

  logic [W-1:0] count_d;
  logic [W-1:0] count_q;
  logic [W-1:0] half_pt;

  if (W < 1 || W > 8) begin : g_bad_width
    $error("ascc_divider: width out of range");
  end

  // Rise on the edge that leaves the start state, fall at mid count
  always_comb begin
    half_pt      = W'(({1'b0, port_if.last} + 1'b1) >> 1);   // Extra bit keeps last+1 from wrapping
    port_if.tick = port_if.edge_in && !port_if.clear && (count_q == '0);   // RULE_03
    port_if.half = port_if.edge_in && !port_if.clear && (port_if.last != '0)
                   && (count_q == half_pt);
    count_d      = count_q;
    if (port_if.clear) begin
      count_d = '0;                                                        // RULE_08
    end else if (port_if.edge_in) begin
      count_d = (count_q >= port_if.last) ? '0 : W'(count_q + 1'b1);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign port_if.count = count_q;

  property p_div_wrap;
    @(posedge clock) disable iff (reset)
      port_if.edge_in && !port_if.clear && (count_q == port_if.last) |=> (count_q == '0);
  endproperty
  a_div_wrap: assert property (p_div_wrap) else $error("divider did not wrap"); // RULE_03

  property p_div_clear;
    @(posedge clock) disable iff (reset)
      port_if.clear |=> (count_q == '0) && !$past(port_if.tick);
  endproperty
  a_div_clear: assert property (p_div_clear) else $error("divider not cleared"); // RULE_08

endmodule

// File: rtl/ascc_top.sv
`timescale 1ns/1ps
module ascc_top #(
  parameter int REF_W      = 5,
  parameter int PERIOD_W   = 8,
  parameter int RELOCK_CYC = ascc_pkg::DCS_RELOCK_CYC
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             reg_wr_en,
  input  wire logic             reg_rd_en,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wr_data,
  output logic      [7:0]       reg_rd_data,
  input  wire logic             nyq_clk_rise,
  input  wire logic             nyq_clk_fall,
  input  wire logic             rf_clock_input_rise,
  input  wire logic             sysref_pin,
  input  wire logic             power_down_pin,
  input  wire logic             spi_power_down,
  input  wire logic             spi_standby,
  input  wire logic             spi_duty_cycle_stabilizer_en,
  input  wire logic [REF_W-1:0] spi_ref_adjust,
  output logic                  sample_tick,
  output logic                  sample_clk,
  output logic                  duty_cycle_stabilizer_active,
  output logic                  ref_enable,
  output logic                  ref_buffer_enable,
  output logic                  bias_enable,
  output logic                  clock_enable,
  output logic      [REF_W-1:0] ref_adjust
);

  localparam int RELOCK_W = $clog2(RELOCK_CYC + 1);
  localparam logic [PERIOD_W-1:0] MAX_PERIOD = PERIOD_W'(ascc_pkg::DCS_MAX_PERIOD);
  localparam logic [RELOCK_W-1:0] RELOCK_LD  = RELOCK_W'(RELOCK_CYC);

  if (PERIOD_W < 4 || PERIOD_W > 16 || RELOCK_CYC < 1 || REF_W < 1) begin : g_bad_param
    $error("ascc_top: parameter out of range");
  end
  if (ascc_pkg::DCS_MAX_PERIOD >= (1 << PERIOD_W) - 1) begin : g_bad_period
    $error("ascc_top: period counter too narrow");
  end

  // Saturating increment for free-running counters
  function automatic logic [PERIOD_W-1:0] sat_inc(input logic [PERIOD_W-1:0] v);
    sat_inc = (v == '1) ? v : PERIOD_W'(v + 1'b1);
  endfunction

  // ---------------- Register port ----------------
  logic [ascc_pkg::DIV_W-1:0] ratio_d;
  logic [ascc_pkg::DIV_W-1:0] ratio_q;
  logic                       src_rf_d;
  logic                       src_rf_q;
  logic                       every_d;
  logic                       every_q;
  logic                       once_d;
  logic                       once_q;
  logic                       armed_d;
  logic                       armed_q;
  logic [7:0]                 rd_data_d;
  logic [7:0]                 rd_data_q;
  logic                       wr_ratio;
  logic                       wr_src;
  logic                       wr_resync;
  logic                       cfg_change;
  logic                       accept;

  // Decode writes; a write that arms the one-shot beats a pulse taken in the same cycle
  always_comb begin
    wr_ratio  = reg_wr_en && (reg_addr == ascc_pkg::ADDR_DIV_RATIO);
    wr_src    = reg_wr_en && (reg_addr == ascc_pkg::ADDR_SRC_SEL);
    wr_resync = reg_wr_en && (reg_addr == ascc_pkg::ADDR_RESYNC);
    ratio_d   = wr_ratio ? reg_wr_data[ascc_pkg::DIV_LSB +: ascc_pkg::DIV_W] : ratio_q; // RULE_05
    src_rf_d  = wr_src ? reg_wr_data[ascc_pkg::SRC_RF_BIT] : src_rf_q;                    // RULE_02
    every_d   = wr_resync ? reg_wr_data[ascc_pkg::RESYNC_EVERY_BIT] : every_q;            // RULE_07
    once_d    = wr_resync ? reg_wr_data[ascc_pkg::RESYNC_ONCE_BIT] : once_q;
    armed_d   = armed_q;
    if (wr_resync && reg_wr_data[ascc_pkg::RESYNC_ONCE_BIT]) begin
      armed_d = 1'b1;                                                                     // RULE_07
    end else if (accept) begin
      armed_d = 1'b0;
    end
    cfg_change = (ratio_d != ratio_q) || (src_rf_d != src_rf_q);                          // RULE_19
    rd_data_d  = 8'h00;
    if (reg_rd_en) begin
      unique case (reg_addr)
        ascc_pkg::ADDR_DIV_RATIO: rd_data_d[ascc_pkg::DIV_LSB +: ascc_pkg::DIV_W] = ratio_q;
        ascc_pkg::ADDR_SRC_SEL:   rd_data_d[ascc_pkg::SRC_RF_BIT] = src_rf_q;
        ascc_pkg::ADDR_RESYNC: begin
          rd_data_d[ascc_pkg::RESYNC_EVERY_BIT] = every_q;
          rd_data_d[ascc_pkg::RESYNC_ONCE_BIT]  = once_q;
        end
        default: rd_data_d = 8'h00;
      endcase
    end else begin
      rd_data_d = rd_data_q;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ratio_q   <= ascc_pkg::RST_DIV_RATIO[ascc_pkg::DIV_LSB +: ascc_pkg::DIV_W];
      src_rf_q  <= ascc_pkg::RST_SRC_SEL[ascc_pkg::SRC_RF_BIT];
      every_q   <= ascc_pkg::RST_RESYNC[ascc_pkg::RESYNC_EVERY_BIT];
      once_q    <= ascc_pkg::RST_RESYNC[ascc_pkg::RESYNC_ONCE_BIT];
      armed_q   <= 1'b0;
      rd_data_q <= 8'h00;
    end else begin
      ratio_q   <= ratio_d;
      src_rf_q  <= src_rf_d;
      every_q   <= every_d;
      once_q    <= once_d;
      armed_q   <= armed_d;
      rd_data_q <= rd_data_d;
    end
  end

  assign reg_rd_data = rd_data_q;

  // ---------------- Pin synchronisers ----------------
  logic sysref_s1_q;
  logic sysref_s2_q;
  logic sysref_s3_q;
  logic pd_s1_q;
  logic pd_s2_q;
  logic sysref_rise;

  // Two stages before use; third stage only for the edge detect
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sysref_s1_q <= 1'b0;
      sysref_s2_q <= 1'b0;
      sysref_s3_q <= 1'b0;
      pd_s1_q     <= 1'b0;
      pd_s2_q     <= 1'b0;
    end else begin
      sysref_s1_q <= sysref_pin;
      sysref_s2_q <= sysref_s1_q;
      sysref_s3_q <= sysref_s2_q;
      pd_s1_q     <= power_down_pin;
      pd_s2_q     <= pd_s1_q;
    end
  end

  assign sysref_rise = sysref_s2_q && !sysref_s3_q;
  assign accept      = sysref_rise && (every_q || armed_q);          // RULE_07

  // ---------------- Predivider and divider ----------------
  ascc_div_if #(.W(ascc_pkg::PREDIV_W)) pre_if ();
  ascc_div_if #(.W(ascc_pkg::DIV_W))    div_if ();
  logic src_rise;
  logic src_fall;

  // RF edges pass the fixed predivider; both stages restart on an accepted pulse
  always_comb begin
    pre_if.edge_in = rf_clock_input_rise;                            // RULE_01
    pre_if.clear   = accept;                                         // RULE_08
    pre_if.last    = ascc_pkg::PREDIV_W'(ascc_pkg::RF_PREDIV - 1);
    src_rise       = src_rf_q ? pre_if.tick : nyq_clk_rise;          // RULE_04
    src_fall       = src_rf_q ? pre_if.half : nyq_clk_fall;
    div_if.edge_in = src_rise;
    div_if.clear   = accept;                                         // RULE_08
    div_if.last    = ratio_q;                                        // RULE_05
  end

  ascc_divider #(.W(ascc_pkg::PREDIV_W)) u_prediv (
    .clock   (clock),
    .reset   (reset),
    .port_if (pre_if.div)
  );

  ascc_divider #(.W(ascc_pkg::DIV_W)) u_div (
    .clock   (clock),
    .reset   (reset),
    .port_if (div_if.div)
  );

  // ---------------- Duty-cycle stabilizer ----------------
  logic [PERIOD_W-1:0] period_d;
  logic [PERIOD_W-1:0] period_q;
  logic [PERIOD_W-1:0] last_period_d;
  logic [PERIOD_W-1:0] last_period_q;
  logic [RELOCK_W-1:0] relock_d;
  logic [RELOCK_W-1:0] relock_q;
  logic                slow_d;
  logic                slow_q;
  logic                locked_d;
  logic                locked_q;
  logic                clk_d;
  logic                clk_q;
  logic                tick_d;
  logic                tick_q;
  logic                dcs_req;
  logic                jump;
  logic                run;

  // Period is measured in system cycles; a change of more than one cycle counts as a
  // frequency step, since edge sampling alone jitters the count by one
  always_comb begin
    dcs_req       = spi_duty_cycle_stabilizer_en || (ratio_q != '0);                  // RULE_06
    period_d      = div_if.tick ? PERIOD_W'(1) : sat_inc(period_q);
    last_period_d = div_if.tick ? period_q : last_period_q;
    jump          = div_if.tick && ((period_q > PERIOD_W'(last_period_q + 1'b1)) ||
                                    (last_period_q > PERIOD_W'(period_q + 1'b1)));
    slow_d        = div_if.tick ? (period_q > MAX_PERIOD)
                                : (slow_q || (period_q > MAX_PERIOD));                 // RULE_10
    if (cfg_change || jump) begin
      relock_d = RELOCK_LD;                                                           // RULE_19
    end else if (relock_q != '0) begin
      relock_d = RELOCK_W'(relock_q - 1'b1);                                          // RULE_11
    end else begin
      relock_d = relock_q;
    end
    locked_d = dcs_req && !slow_d && (relock_d == '0);                                // RULE_10
    tick_d   = div_if.tick && run;                                                    // RULE_18
    clk_d    = clk_q;
    if (!run) begin
      clk_d = 1'b0;                                                                   // RULE_15
    end else if (div_if.tick) begin
      clk_d = 1'b1;                                                                   // RULE_09
    end else if (clk_q && locked_q) begin
      clk_d = (period_q == (last_period_q >> 1)) ? 1'b0 : 1'b1;                       // RULE_09
    end else if (clk_q && src_fall) begin
      clk_d = 1'b0;                                                                   // RULE_12
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      period_q      <= '0;
      last_period_q <= '0;
      relock_q      <= RELOCK_LD;
      slow_q        <= 1'b1;
      locked_q      <= 1'b0;
      clk_q         <= 1'b0;
      tick_q        <= 1'b0;
    end else begin
      period_q      <= period_d;
      last_period_q <= last_period_d;
      relock_q      <= relock_d;
      slow_q        <= slow_d;
      locked_q      <= locked_d;
      clk_q         <= clk_d;
      tick_q        <= tick_d;
    end
  end

  assign sample_tick                  = tick_q;
  assign sample_clk                   = clk_q;
  assign duty_cycle_stabilizer_active = locked_q;

  // ---------------- Power modes ----------------
  ascc_pkg::ascc_pwr_t pwr_d;
  ascc_pkg::ascc_pwr_t pwr_q;
  logic                ref_en_d;
  logic                refbuf_en_d;
  logic                bias_en_d;
  logic                clk_en_d;
  logic                ref_en_q;
  logic                refbuf_en_q;
  logic                bias_en_q;
  logic                clk_en_q;
  logic [REF_W-1:0]    ref_adj_q;

  // Either request holds power-down; pin low alone releases only its own request
  always_comb begin
    if (pd_s2_q || spi_power_down) begin
      pwr_d = ascc_pkg::ASCC_PWR_DOWN;                                                // RULE_13
    end else if (spi_standby) begin
      pwr_d = ascc_pkg::ASCC_PWR_STANDBY;                                             // RULE_16
    end else begin
      pwr_d = ascc_pkg::ASCC_PWR_RUN;                                                 // RULE_14
    end
    unique case (pwr_d)
      ascc_pkg::ASCC_PWR_RUN: begin
        {ref_en_d, refbuf_en_d, bias_en_d, clk_en_d} = 4'hF;
      end
      ascc_pkg::ASCC_PWR_STANDBY: begin
        {ref_en_d, refbuf_en_d, bias_en_d, clk_en_d} = 4'hC;                          // RULE_16
      end
      default: begin
        {ref_en_d, refbuf_en_d, bias_en_d, clk_en_d} = 4'h0;                          // RULE_15
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pwr_q       <= ascc_pkg::ASCC_PWR_DOWN;
      ref_en_q    <= 1'b0;
      refbuf_en_q <= 1'b0;
      bias_en_q   <= 1'b0;
      clk_en_q    <= 1'b0;
      ref_adj_q   <= '0;
    end else begin
      pwr_q       <= pwr_d;
      ref_en_q    <= ref_en_d;
      refbuf_en_q <= refbuf_en_d;
      bias_en_q   <= bias_en_d;
      clk_en_q    <= clk_en_d;
      ref_adj_q   <= spi_ref_adjust;                                                  // RULE_17
    end
  end

  assign run               = clk_en_q;
  assign ref_enable        = ref_en_q;
  assign ref_buffer_enable = refbuf_en_q;
  assign bias_enable       = bias_en_q;
  assign clock_enable      = clk_en_q;
  assign ref_adjust        = ref_adj_q;

  // ---------------- Assertions ----------------
  property p_src_default;
    @(posedge clock) disable iff (reset)
      $fell(reset) |-> !src_rf_q && (ratio_q == '0);
  endproperty
  a_src_default: assert property (p_src_default) else $error("bad config after reset"); // RULE_02

  property p_rf_prediv;
    @(posedge clock) disable iff (reset)
      src_rf_q && div_if.edge_in |-> pre_if.tick && rf_clock_input_rise;
  endproperty
  a_rf_prediv: assert property (p_rf_prediv) else $error("RF edge skipped predivider"); // RULE_04

  property p_dcs_forced;
    @(posedge clock) disable iff (reset)
      (ratio_q != '0) && !spi_duty_cycle_stabilizer_en |-> dcs_req;
  endproperty
  a_dcs_forced: assert property (p_dcs_forced) else $error("stabilizer not forced"); // RULE_06

  property p_once_disarm;
    @(posedge clock) disable iff (reset)
      sysref_rise && !every_q && armed_q && !wr_resync |=> !armed_q ##1 !accept;
  endproperty
  a_once_disarm: assert property (p_once_disarm) else $error("one-shot not disarmed"); // RULE_07

  property p_relock_hold;
    @(posedge clock) disable iff (reset)
      cfg_change |=> !locked_q [*8];
  endproperty
  a_relock_hold: assert property (p_relock_hold) else $error("locked too soon"); // RULE_19

  property p_slow_off;
    @(posedge clock) disable iff (reset)
      slow_q |-> !duty_cycle_stabilizer_active;
  endproperty
  a_slow_off: assert property (p_slow_off) else $error("stabilizer active when slow"); // RULE_10

  property p_bypass_fall;
    @(posedge clock) disable iff (reset)
      !locked_q && clk_q && src_fall && !div_if.tick && run |=> !sample_clk;
  endproperty
  a_bypass_fall: assert property (p_bypass_fall) else $error("bypass fall missed"); // RULE_12

  property p_pin_down;
    @(posedge clock) disable iff (reset)
      pd_s2_q |=> (pwr_q == ascc_pkg::ASCC_PWR_DOWN) && !clock_enable && !ref_enable
                  && !ref_buffer_enable && !bias_enable;
  endproperty
  a_pin_down: assert property (p_pin_down) else $error("power-down not entered"); // RULE_15

  property p_standby;
    @(posedge clock) disable iff (reset)
      spi_standby && !spi_power_down && !pd_s2_q |=> ref_enable && ref_buffer_enable
                                                     && !clock_enable;
  endproperty
  a_standby: assert property (p_standby) else $error("standby levels wrong"); // RULE_16

  property p_sample_edge;
    @(posedge clock) disable iff (reset)
      div_if.tick && run |=> sample_tick && sample_clk;
  endproperty
  a_sample_edge: assert property (p_sample_edge) else $error("sample edge missing"); // RULE_18

endmodule
